//--- pkg/usb_otg_event_map.svh
// Register offsets, field positions, reset values and timing counts of the OTG event block.
// Assumes a byte-addressed register port with one aligned 32-bit word per register.
`ifndef USB_OTG_EVENT_MAP_SVH
`define USB_OTG_EVENT_MAP_SVH

// Byte offsets of the three registers.
`define OTG_FLAGS_OFFSET    8'h00
`define OTG_ENABLES_OFFSET  8'h04
`define OTG_STATUS_OFFSET   8'h08

// Field positions shared by the flag and enable registers.
`define OTG_BIT_ID          7
`define OTG_BIT_TIMER       6
`define OTG_BIT_LINE        5
`define OTG_BIT_ACTIVITY    4
`define OTG_BIT_SESS_VALID  3
`define OTG_BIT_SESS_END    2
`define OTG_BIT_VBUS_VALID  0

// Mask of implemented bits in the flag and enable registers.
`define OTG_EVENT_MASK      8'hFD
// Mask of implemented bits in the status register.
`define OTG_STATUS_MASK     8'hAD

// Reset values.
`define OTG_FLAGS_RESET     8'h00
`define OTG_ENABLES_RESET   8'h00
`define OTG_LINE_RESET      2'h0

// Timing: the millisecond period in microseconds and the clock rate in MHz.
`define OTG_MS_TIME_US      1000
`define OTG_CLK_MHZ         40
`define OTG_MS_CYCLES       (`OTG_MS_TIME_US * `OTG_CLK_MHZ)

`endif

//--- pkg/usb_otg_event_pkg.sv
// Types shared by the OTG event block and its helper modules.
// Assumes the constants header is included where offsets or counts are needed.
package usb_otg_event_pkg;

    // One byte of implemented event, enable or status bits.
    typedef logic [7:0] otg_bits_t;

    // Sampled USB line state: single-ended zero and J state.
    typedef struct packed {
        logic se0;
        logic j_state;
    } line_state_t;

endpackage

//--- pkg/otg_evt_if.sv
// Interface carrying the millisecond tick and the line-state monitor signals.
// Assumes all members are synchronous to the single system clock.
`timescale 1ns/10ps
interface otg_evt_if;
    import usb_otg_event_pkg::*;

    // One-cycle pulse each time the millisecond timer expires.
    logic        ms_tick;
    // Line state presented to the monitor.
    line_state_t line_now;
    // Line state has been unchanged for a whole millisecond.
    logic        line_stable;
    // One-cycle pulse: a new stable value differs from the last reported one.
    logic        line_changed;

    modport timer   (output ms_tick);
    modport monitor (input line_now, output line_stable, output line_changed);
    modport core    (input ms_tick, output line_now, input line_stable, input line_changed);
endinterface

//--- hdl/ms_tick_gen.sv
// Free-running divider that issues a one-cycle tick every millisecond.
// Assumes a single system clock with a synchronous active-high reset.
`timescale 1ns/10ps
module ms_tick_gen
#(
    parameter int MS_CYCLES = 40000
)
(
    // Clock and reset.
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    // Tick output.
    otg_evt_if.timer  evt
);
    localparam int CNT_W = $clog2(MS_CYCLES);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(MS_CYCLES - 1);

    logic [CNT_W-1:0] count_reg;

    // Counts cycles and wraps once per millisecond.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            count_reg <= '0;
        end else if (count_reg == LAST) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // Raises the tick in the same cycle that the count wraps to zero.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            evt.ms_tick <= 1'b0;
        end else begin
            evt.ms_tick <= (count_reg == LAST);
        end
    end
endmodule

//--- hdl/line_stable_mon.sv
// Watches the line state and reports when it has held still for one millisecond.
// Assumes the line state input is already sampled on the system clock.
`timescale 1ns/10ps
`include "usb_otg_event_map.svh"
module line_stable_mon
    import usb_otg_event_pkg::*;
#(
    parameter int MS_CYCLES = 40000
)
(
    // Clock and reset.
    input  wire logic  sys_clk_i,
    input  wire logic  sys_rst_i,
    // Line state in, stability out.
    otg_evt_if.monitor evt
);
    localparam int CNT_W = $clog2(MS_CYCLES + 1);
    localparam logic [CNT_W-1:0] FULL = CNT_W'(MS_CYCLES);

    line_state_t      last_reg;
    line_state_t      reported_reg;
    logic [CNT_W-1:0] hold_reg;

    // Remembers the previous line state to spot any change.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            last_reg <= `OTG_LINE_RESET;
        end else begin
            last_reg <= evt.line_now;
        end
    end

    // Counts unchanged cycles and saturates at one millisecond.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            hold_reg <= '0;
        end else if (evt.line_now != last_reg) begin
            hold_reg <= '0;
        end else if (hold_reg != FULL) begin
            hold_reg <= hold_reg + 1'b1;
        end
    end

    // Stable indication while the count is saturated and the line still matches.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            evt.line_stable <= 1'b0;
        end else begin
            evt.line_stable <= (hold_reg == FULL) && (evt.line_now == last_reg);
        end
    end

    // Pulses once when a fresh stable value differs from the last reported one.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            reported_reg     <= `OTG_LINE_RESET;
            evt.line_changed <= 1'b0;
        end else if ((hold_reg == FULL - 1'b1) && (evt.line_now == last_reg)) begin
            reported_reg     <= last_reg;
            evt.line_changed <= (last_reg != reported_reg);
        end else begin
            evt.line_changed <= 1'b0;
        end
    end
endmodule

//--- hdl/usb_otg_event_status.sv
// OTG event, enable and status registers with their event detectors.
// Assumes all pin and comparator inputs are synchronous to sys_clk_i and that
// the register port follows single-cycle strobes with read data one cycle later.
`timescale 1ns/10ps
`include "usb_otg_event_map.svh"
module usb_otg_event_status
    import usb_otg_event_pkg::*;
#(
    parameter int MS_CYCLES = `OTG_MS_CYCLES
)
(
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // Register port.
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // Cable pins and comparators.
    input  wire logic        dp_i,
    input  wire logic        dm_i,
    input  wire logic        id_pin_i,
    input  wire logic        sess_valid_i,
    input  wire logic        sess_end_i,
    // Line state from the transceiver.
    input  wire logic        se0_i,
    input  wire logic        line_j_state_i,
    // Device is asleep or suspended, so bus activity wakes it.
    input  wire logic        suspended_i,
    // Interrupt request.
    output logic             irq_o
);
    // Shared tick and line-state signals between the helper modules.
    otg_evt_if evt ();

    // Sampled inputs, one cycle behind the pins.
    logic       dp_reg;
    logic       dm_reg;
    logic       id_reg;
    logic       sess_valid_reg;
    logic       sess_end_reg;

    // Register contents.
    otg_bits_t  flags_reg;
    otg_bits_t  flags_next;
    otg_bits_t  enables_reg;
    otg_bits_t  status_reg;
    otg_bits_t  event_set;
    otg_bits_t  clear_mask;

    // Edge indications from the sampled inputs.
    logic       id_edge;
    logic       sess_valid_edge;
    logic       sess_end_edge;
    logic       sess_end_rise;
    logic       pin_activity;

    // Decodes one register offset against the port address.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == offset);
    endfunction

    // Millisecond timer.
    ms_tick_gen #(
        .MS_CYCLES (MS_CYCLES)
    ) u_ms_tick (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .evt       (evt)
    );

    // Line stability monitor.
    line_stable_mon #(
        .MS_CYCLES (MS_CYCLES)
    ) u_line_mon (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .evt       (evt)
    );

    // Presents the current line state to the monitor.
    always_comb begin
        evt.line_now.se0     = se0_i;
        evt.line_now.j_state = line_j_state_i;
    end

    // Samples the cable pins and comparators for edge detection.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            dp_reg         <= 1'b0;
            dm_reg         <= 1'b0;
            id_reg         <= 1'b1;
            sess_valid_reg <= 1'b0;
            sess_end_reg   <= 1'b0;
        end else begin
            dp_reg         <= dp_i;
            dm_reg         <= dm_i;
            id_reg         <= id_pin_i;
            sess_valid_reg <= sess_valid_i;
            sess_end_reg   <= sess_end_i;
        end
    end

    // Edge detectors on the sampled inputs.
    always_comb begin
        id_edge         = (id_pin_i != id_reg);
        sess_valid_edge = (sess_valid_i != sess_valid_reg);
        sess_end_edge   = (sess_end_i != sess_end_reg);
        sess_end_rise   = sess_end_i & ~sess_end_reg;
        pin_activity    = suspended_i & ((dp_i != dp_reg) | (dm_i != dm_reg) |
                                         id_edge | sess_valid_edge);
    end

    // Gathers this cycle's hardware events into bit positions.
    always_comb begin
        event_set                      = '0;
        event_set[`OTG_BIT_ID]         = id_edge;
        event_set[`OTG_BIT_TIMER]      = evt.ms_tick;
        event_set[`OTG_BIT_LINE]       = evt.line_changed;
        event_set[`OTG_BIT_ACTIVITY]   = pin_activity;
        event_set[`OTG_BIT_SESS_VALID] = sess_end_rise;
        event_set[`OTG_BIT_SESS_END]   = sess_end_edge;
        event_set[`OTG_BIT_VBUS_VALID] = sess_valid_edge;
    end

    // Write-one-to-clear mask for the flag register.
    always_comb begin
        clear_mask = '0;
        if (reg_wr_i && hit(reg_addr_i, `OTG_FLAGS_OFFSET)) begin
            clear_mask = reg_wdata_i[7:0] & `OTG_EVENT_MASK;
        end
    end

    // Next flag value per bit: a set outranks a clear in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_flag
            always_comb begin
                if (event_set[gi]) begin
                    flags_next[gi] = 1'b1;
                end else if (clear_mask[gi]) begin
                    flags_next[gi] = 1'b0;
                end else begin
                    flags_next[gi] = flags_reg[gi];
                end
            end
        end
    endgenerate

    // Holds the sticky event flags; unimplemented bits stay zero.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            flags_reg <= `OTG_FLAGS_RESET;
        end else begin
            flags_reg <= flags_next & `OTG_EVENT_MASK;
        end
    end

    // Holds the interrupt enable bits written by software.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            enables_reg <= `OTG_ENABLES_RESET;
        end else if (reg_wr_i && hit(reg_addr_i, `OTG_ENABLES_OFFSET)) begin
            enables_reg <= reg_wdata_i[7:0] & `OTG_EVENT_MASK;
        end
    end

    // Live status bits; the identification pin high means a B device.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            status_reg <= '0;
        end else begin
            status_reg                      <= '0;
            status_reg[`OTG_BIT_ID]         <= id_pin_i;
            status_reg[`OTG_BIT_LINE]       <= evt.line_stable;
            status_reg[`OTG_BIT_SESS_VALID] <= sess_valid_i;
            status_reg[`OTG_BIT_SESS_END]   <= id_pin_i & ~sess_valid_i;
            status_reg[`OTG_BIT_VBUS_VALID] <= ~id_pin_i & sess_valid_i;
        end
    end

    // Read data register: valid only in the cycle after the read strobe.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= '0;
        end else if (hit(reg_addr_i, `OTG_FLAGS_OFFSET)) begin
            reg_rdata_o <= {24'h000000, flags_reg};
        end else if (hit(reg_addr_i, `OTG_ENABLES_OFFSET)) begin
            reg_rdata_o <= {24'h000000, enables_reg};
        end else if (hit(reg_addr_i, `OTG_STATUS_OFFSET)) begin
            reg_rdata_o <= {24'h000000, status_reg & `OTG_STATUS_MASK};
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // Interrupt request from any flag whose enable is set.
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags_reg & enables_reg);
        end
    end
endmodule

//--- tb/usb_otg_event_assertions.sv
// Port-level assertions for the OTG event block.
// Assumes one-cycle strobes and status reads made with the pins steady.
`timescale 1ns/10ps
module usb_otg_event_assertions (
    // Clock and reset.
    input wire logic        sys_clk_i,
    input wire logic        sys_rst_i,
    // Register port.
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    // Pins and request.
    input wire logic        id_pin_i,
    input wire logic        sess_valid_i,
    input wire logic        sess_end_i,
    input wire logic        irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // A read of the flag register.
    sequence s_flag_rd;
        reg_rd_i && reg_addr_i == 8'h00;
    endsequence
    // A status read with the pins held for a cycle.
    sequence s_stat_rd;
        reg_rd_i && reg_addr_i == 8'h08 && !$past(sys_rst_i)
            && $stable(id_pin_i) && $stable(sess_valid_i);
    endsequence
    // A pin edge followed at once by a flag read shows the flag.
    property p_edge(logic s, int b);
        !$past(sys_rst_i) && $changed(s) ##1 s_flag_rd |=> reg_rdata_o[b];
    endproperty
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside a read slot");
    chk_unimpl_zero: assert property ($past(reg_rd_i) |->
        reg_rdata_o[31:8] == 24'h0 && !reg_rdata_o[1]) else $error("unused bits set");
    chk_stat_id: assert property (s_stat_rd |=> reg_rdata_o[7] == $past(id_pin_i))
        else $error("status id bit wrong");
    chk_stat_sess: assert property (s_stat_rd |=>
        reg_rdata_o[3] == $past(sess_valid_i)) else $error("session valid bit wrong");
    chk_stat_avbus: assert property (s_stat_rd |=>
        reg_rdata_o[0] == $past(!id_pin_i && sess_valid_i)) else $error("vbus bit wrong");
    chk_id_flag: assert property (p_edge(id_pin_i, 7))
        else $error("id change not flagged");
    chk_send_flag: assert property (p_edge(sess_end_i, 2))
        else $error("session end change not flagged");
    chk_en_readback: assert property (reg_wr_i && reg_addr_i == 8'h04 ##1 !reg_wr_i ##1
        reg_rd_i && reg_addr_i == 8'h04
        |=> reg_rdata_o[7:0] == ($past(reg_wdata_i[7:0], 3) & 8'hFD))
        else $error("enable readback wrong");
    chk_irq_masked: assert property (reg_wr_i && reg_addr_i == 8'h04
        && reg_wdata_i[7:0] == 8'h00 |=> ##1 !irq_o) else $error("masked request stays");
endmodule
bind usb_otg_event_status usb_otg_event_assertions i_chk (.sys_clk_i, .sys_rst_i,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .id_pin_i,
    .sess_valid_i, .sess_end_i, .irq_o);

//--- tb/usb_cable_model.sv
// Behavioural cable: D+ and D- levels, identification pin, comparators, line state.
// Assumes the bench calls set_pins, which moves the pins just after a clock edge.
`timescale 1ns/10ps
module usb_cable_model (
    // Clock.
    input  wire logic sys_clk_i,
    // Cable side levels.
    output logic      dp_o,
    output logic      dm_o,
    output logic      id_o,
    output logic      sess_valid_o,
    output logic      sess_end_o,
    output logic      se0_o,
    output logic      j_state_o
);
    // An unplugged, unpowered port: identification pin pulled high.
    initial {dp_o, dm_o, id_o, sess_valid_o, sess_end_o, se0_o, j_state_o} = 7'h10;
    // Every level moves together, one edge after the call.
    task automatic set_pins(input logic [6:0] v);
        @(posedge sys_clk_i);
        {dp_o, dm_o, id_o, sess_valid_o, sess_end_o, se0_o, j_state_o} <= v;
    endtask
endmodule

//--- tb/usb_otg_event_status_tb.sv
// Self-checking bench for the OTG event block with a 20-cycle millisecond.
// Assumes the cable model drives the pins and the bench owns the register port.
`timescale 1ns/10ps
module usb_otg_event_status_tb;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic        reg_wr_i = 1'b0;
    logic        reg_rd_i = 1'b0;
    logic        suspended_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic        irq_o;
    logic        dp_i, dm_i, id_pin_i, sess_valid_i, sess_end_i, se0_i, line_j_state_i;
    logic [31:0] d;
    logic [6:0]  cs = 7'h10;
    int          n;
    int          mismatches = 0;
    int          samples_checked = 0;
    // Shortened millisecond in clock cycles; kept even so the timer poll count is exact.
    localparam int MS = 20;
    // A 40 MHz clock.
    always #12.5 sys_clk_i = ~sys_clk_i;
    usb_otg_event_status #(.MS_CYCLES(MS)) i_dut (.sys_clk_i, .sys_rst_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .dp_i, .dm_i, .id_pin_i,
        .sess_valid_i, .sess_end_i, .se0_i, .line_j_state_i, .suspended_i, .irq_o);
    usb_cable_model i_cable (.sys_clk_i, .dp_o(dp_i), .dm_o(dm_i), .id_o(id_pin_i),
        .sess_valid_o(sess_valid_i), .sess_end_o(sess_end_i), .se0_o(se0_i),
        .j_state_o(line_j_state_i));
    // Compares one value and counts it.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= v;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // One-cycle register read; data taken in the following cycle.
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1; reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // New cable state: {dp, dm, id, valid, end, se0, j}.
    task automatic put(input logic [6:0] v);
        cs = v;
        i_cable.set_pins(v);
    endtask
    // Reset values, unused bits, read-only status and an unmapped address.
    task automatic t_regs;
        rd(8'h00); chk(d, 32'h0);
        rd(8'h04); chk(d, 32'h0);
        rd(8'h08); chk(d, 32'h84);
        rd(8'h0C); chk(d, 32'h0);
        wr(8'h04, 32'hFFFFFFFF); rd(8'h04); chk(d, 32'hFD);
        wr(8'h08, 32'hFFFFFFFF); wr(8'h0C, 32'hFFFFFFFF);
        rd(8'h08); chk(d & 32'hFFFFFFDF, 32'h84);
        wr(8'h04, 32'h0); rd(8'h04); chk(d, 32'h0);
    endtask
    // Cable identification change, request, write-one clear and set-beats-clear.
    task automatic t_id;
        wr(8'h00, 32'hFF); wr(8'h04, 32'h80); put(cs & 7'h6F);
        rd(8'h00); chk(d[7], 1);
        chk(irq_o, 1);
        rd(8'h08); chk(d[7], 0);
        wr(8'h00, 32'h0); rd(8'h00); chk(d[7], 1);
        wr(8'h00, 32'h80); rd(8'h00); chk(d[7], 0);
        chk(irq_o, 0);
        fork put(cs | 7'h10); wr(8'h00, 32'h80); join
        rd(8'h00); chk(d[7], 1);
        wr(8'h04, 32'h0); rd(8'h08); chk(d[7], 1);
    endtask
    // Comparator edges and the A or B device status bits.
    task automatic t_vbus;
        put(cs & 7'h6F); wr(8'h00, 32'hFF); put(cs | 7'h08);
        rd(8'h00); chk(d[0], 1);
        rd(8'h08); chk(d & 32'h8D, 32'h09);
        put(cs | 7'h04); rd(8'h00); chk(d & 32'h0C, 32'h0C);
        wr(8'h00, 32'hFF); put(cs & 7'h77 | 7'h10);
        rd(8'h00); chk(d[0], 1);
        rd(8'h08); chk(d & 32'h8D, 32'h84);
    endtask
    // Bus activity counts only while suspended.
    task automatic t_act;
        wr(8'h00, 32'hFF); put(cs ^ 7'h40); rd(8'h00); chk(d[4], 0);
        @(posedge sys_clk_i) suspended_i <= 1'b1;
        put(cs ^ 7'h20); rd(8'h00); chk(d[4], 1);
        @(posedge sys_clk_i) suspended_i <= 1'b0;
    endtask
    // Line state must hold a whole millisecond before it is reported.
    task automatic t_line;
        wr(8'h00, 32'hFF); put(cs | 7'h02);
        repeat (10) @(posedge sys_clk_i);
        rd(8'h08); chk(d[5], 0);
        rd(8'h00); chk(d[5], 0);
        repeat (15) @(posedge sys_clk_i);
        rd(8'h08); chk(d[5], 1);
        rd(8'h00); chk(d[5], 1);
    endtask
    // Polls the flag register until the timer flag appears.
    task automatic poll;
        n = 0;
        do begin
            rd(8'h00);
            n++;
        end while (d[6] !== 1'b1 && n < 40);
    endtask
    // The timer flag comes back once every millisecond. After a poll has just seen
    // a fresh tick, a two-cycle clear and two-cycle reads need MS/2-1 reads for the next.
    task automatic t_timer;
        poll(); chk(n < 12, 1);
        wr(8'h00, 32'h40); poll(); chk(n < 12, 1);
        wr(8'h00, 32'h40); poll(); chk(n, MS / 2 - 1);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("mismatches %0d, samples checked %0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Main sequence after a 16-cycle reset.
    initial begin
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        t_regs; t_id; t_vbus; t_act; t_line; t_timer;
        end_sim;
    end
    // Watchdog: the tests need some 200 cycles, so 4000 means a hang.
    initial begin
        #100000;
        mismatches++;
        end_sim;
    end
endmodule
